//--- idq_inbound.sv
// Inbound queue port: packet capture, ordered and bypass FIFOs and credit return
// Summary of operation
// [RQ1] PCIe-mode credit returns carry the dequeued packet's id
// [RQ2] Ordered and bypass queues, 16 entries each
// [RQ3] Sender keeps 16 DMA/int and 16 PIO credits
// [RQ4] Ids reused after ack, response or int reply
// [RQ5] PIO completions accepted with no flow control
// [RQ6] Mode input selects PCIe or network attachment
// [RQ7] PCIe bypass entries wait on youngest ordered entry
// [RQ8] Ordered entries wait on youngest bypass entry
// [RQ9] Sender steers DMA/int ordered, PIO bypass
// [RQ10] Sender stops at sixteenth outstanding credit
// [RQ11] Write dequeue pulses write ack with tag
// [RQ12] One-beat packet: header tells PIO from interrupt
// [RQ13] Sender without credit waits for a return
// [RQ14] Read is one header cycle, no payload
// [RQ15] Sender zeroes low six address bits
// [RQ16] Write header: payload follows, not single beat
// [RQ17] Write beats two-five carry payload and parity
// [RQ18] Byte enables ignored when mask inactive
// [RQ19] Sender decrements credits per read or write
// [RQ20] Next packet taken the cycle after previous
// [RQ21] Ordered writes wait for earlier writes complete
// [RQ22] Reads and writes never allocate cache lines
// [RQ23] Reset empties queues, sender credits full
`timescale 1ns/10ps
module idq_inbound
  import idq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pcie_mode,
  idq_link_if.dev lnk,
  input wire logic l2_writes_idle,
  output logic oq_vld,
  input wire logic oq_ready,
  output idq_kind_t oq_kind,
  output logic [IDQ_DATA_W-1:0] oq_hdr,
  output idq_pay_t oq_pay,
  output idq_be_t oq_be,
  output logic oq_no_alloc,
  output logic bq_vld,
  input wire logic bq_ready,
  output idq_kind_t bq_kind,
  output logic [IDQ_DATA_W-1:0] bq_hdr,
  output idq_pay_t bq_pay,
  output idq_be_t bq_be,
  output logic overflow
);
  typedef enum logic {IDQ_RX_IDLE, IDQ_RX_BEAT} idq_rx_t;

  // ==========================================================
  // Packet capture state
  idq_rx_t rx_r, rx_nxt;
  logic [2:0] beat_r, beat_nxt, last_r, last_nxt;
  logic [IDQ_DATA_W-1:0] hdr_r, hdr_nxt;
  idq_kind_t kind_r, kind_nxt;
  logic byp_r, byp_nxt;
  idq_pay_t pay_r, pay_nxt;
  idq_be_t be_r, be_nxt;
  logic ovf_r, ovf_nxt;

  // Completed packet handed to the queues this cycle
  logic enq_vld, enq_q;
  logic [IDQ_DATA_W-1:0] enq_hdr;
  idq_kind_t enq_kind;
  idq_pay_t enq_pay;
  idq_be_t enq_be;

  // ==========================================================
  // Queue storage, index 0 ordered, 1 bypass
  logic [1:0][IDQ_DEPTH-1:0][IDQ_DATA_W-1:0] e_hdr_r, e_hdr_nxt;
  idq_pay_t [1:0][IDQ_DEPTH-1:0] e_pay_r, e_pay_nxt;
  idq_be_t [1:0][IDQ_DEPTH-1:0] e_be_r, e_be_nxt;
  idq_kind_t [1:0][IDQ_DEPTH-1:0] e_kind_r, e_kind_nxt;
  logic [1:0][IDQ_DEPTH-1:0][IDQ_PTR_W-1:0] e_dep_r, e_dep_nxt;
  logic [1:0][IDQ_DEPTH-1:0] e_hasdep_r, e_hasdep_nxt;
  logic [1:0][IDQ_PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] q_vld, q_rdy, deq, q_full;
  logic [1:0][IDQ_TAG_W-1:0] head_tag;
  logic wrack_r, wrack_nxt;
  logic [IDQ_TAG_W-1:0] wrack_tag_r, wrack_tag_nxt;
  logic [1:0] dq_vld_r, dq_vld_nxt;
  logic [1:0][IDQ_TAG_W-1:0] dq_id_r, dq_id_nxt;

  // Header-cycle classification from the request signals
  function automatic idq_kind_t idq_classify(input logic dr, input logic sb,
                                             input logic [IDQ_DATA_W-1:0] h);
    if (!dr) return IDQ_K_READ;
    if (!sb) return IDQ_K_WRITE;
    return h[IDQ_HDR_INT_BIT] ? IDQ_K_INT : IDQ_K_PIO; // RQ12
  endfunction

  // ==========================================================
  // Capture: no wait states, a header is taken in any idle cycle
  always_comb begin
    rx_nxt = rx_r;
    beat_nxt = beat_r;
    last_nxt = last_r;
    hdr_nxt = hdr_r;
    kind_nxt = kind_r;
    byp_nxt = byp_r;
    pay_nxt = pay_r;
    be_nxt = be_r;
    enq_vld = 1'b0;
    enq_q = byp_r;
    enq_hdr = hdr_r;
    enq_kind = kind_r;
    enq_pay = pay_r;
    enq_be = be_r;
    if (rx_r == IDQ_RX_BEAT) begin
      pay_nxt[beat_r] = lnk.data; // RQ17
      // Mask inactive: lanes taken as all enabled
      be_nxt[beat_r] = hdr_r[IDQ_HDR_BMA_BIT] ? lnk.byte_lane_enables : '1; // RQ18
      beat_nxt = beat_r + 3'h1;
      if (beat_r == last_r) begin
        rx_nxt = IDQ_RX_IDLE; // RQ20
        enq_vld = 1'b1;
        enq_pay = pay_nxt;
        enq_be = be_nxt;
      end
    end else if (lnk.hdr_vld) begin
      hdr_nxt = lnk.data;
      kind_nxt = idq_classify(lnk.datareq, lnk.single_beat_payload, lnk.data);
      byp_nxt = lnk.reqbypass;
      pay_nxt = '0;
      be_nxt = '0;
      beat_nxt = '0;
      last_nxt = (kind_nxt == IDQ_K_WRITE) ? IDQ_LAST_BEAT : 3'h0;
      if (kind_nxt == IDQ_K_READ) begin
        // Reads carry no payload and are queued at once
        enq_vld = 1'b1; // RQ14
        enq_q = lnk.reqbypass;
        enq_hdr = lnk.data;
        enq_kind = IDQ_K_READ;
        enq_pay = '0;
        enq_be = '0;
      end else begin
        rx_nxt = IDQ_RX_BEAT;
      end
    end
  end

  // ==========================================================
  // Drain side: head of each queue and its ordering gates
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      logic [IDQ_TAG_W-1:0] ri;
      ri = rp_r[q][IDQ_TAG_W-1:0];
      q_full[q] = (wp_r[q] - rp_r[q]) == IDQ_PEND_MAX;
      head_tag[q] = e_hdr_r[q][ri][IDQ_HDR_TAG_LSB +: IDQ_TAG_W];
      // Head waits until the other queue drained past its recorded point
      q_rdy[q] = (wp_r[q] != rp_r[q]) &&
                 !(e_hasdep_r[q][ri] && idq_pending(e_dep_r[q][ri], rp_r[1-q])); // RQ7 RQ8
    end
    // Ordered writes only once earlier L2 writes have reached memory
    if (e_kind_r[IDQ_OQ][rp_r[IDQ_OQ][IDQ_TAG_W-1:0]] == IDQ_K_WRITE && !l2_writes_idle) begin
      q_rdy[IDQ_OQ] = 1'b0; // RQ21
    end
    q_vld = ce ? q_rdy : 2'b00;
    deq[IDQ_OQ] = q_vld[IDQ_OQ] && oq_ready;
    deq[IDQ_BQ] = q_vld[IDQ_BQ] && bq_ready;
  end

  // ==========================================================
  // Queue update and credit return
  always_comb begin
    e_hdr_nxt = e_hdr_r;
    e_pay_nxt = e_pay_r;
    e_be_nxt = e_be_r;
    e_kind_nxt = e_kind_r;
    e_dep_nxt = e_dep_r;
    e_hasdep_nxt = e_hasdep_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    ovf_nxt = ovf_r;
    wrack_nxt = 1'b0;
    wrack_tag_nxt = wrack_tag_r;
    dq_vld_nxt = 2'b00;
    dq_id_nxt = dq_id_r;
    for (int q = 0; q < 2; q++) begin
      if (deq[q]) begin
        rp_nxt[q] = rp_r[q] + 5'h1;
        dq_vld_nxt[q] = 1'b1;
        // Network mode returns an anonymous credit
        dq_id_nxt[q] = pcie_mode ? head_tag[q] : '0; // RQ1
      end
    end
    if (deq[IDQ_OQ] && oq_kind == IDQ_K_WRITE) begin
      wrack_nxt = 1'b1; // RQ11
      wrack_tag_nxt = head_tag[IDQ_OQ]; // RQ11
    end
    if (enq_vld) begin
      // Never stalls the link; a sender breaking credit loses the packet
      if (q_full[enq_q]) begin
        ovf_nxt = 1'b1; // RQ5
      end else begin
        e_hdr_nxt[enq_q][wp_r[enq_q][IDQ_TAG_W-1:0]] = enq_hdr; // RQ2
        e_pay_nxt[enq_q][wp_r[enq_q][IDQ_TAG_W-1:0]] = enq_pay;
        e_be_nxt[enq_q][wp_r[enq_q][IDQ_TAG_W-1:0]] = enq_be;
        e_kind_nxt[enq_q][wp_r[enq_q][IDQ_TAG_W-1:0]] = enq_kind;
        // Depend on the youngest entry now in the other queue
        e_dep_nxt[enq_q][wp_r[enq_q][IDQ_TAG_W-1:0]] = wp_r[!enq_q]; // RQ7 RQ8
        e_hasdep_nxt[enq_q][wp_r[enq_q][IDQ_TAG_W-1:0]] = !enq_q || pcie_mode; // RQ6 RQ7
        wp_nxt[enq_q] = wp_r[enq_q] + 5'h1;
      end
    end
  end

  // ==========================================================
  // Registers; reset leaves both queues empty
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_r <= IDQ_RX_IDLE;
      beat_r <= '0;
      last_r <= '0;
      hdr_r <= '0;
      kind_r <= IDQ_K_READ;
      byp_r <= 1'b0;
      pay_r <= '0;
      be_r <= '0;
      ovf_r <= 1'b0;
      e_hdr_r <= '0;
      e_pay_r <= '0;
      e_be_r <= '0;
      e_kind_r <= '{default: IDQ_K_READ};
      e_dep_r <= '0;
      e_hasdep_r <= '0;
      wp_r <= '0; // RQ23
      rp_r <= '0; // RQ23
      wrack_r <= 1'b0;
      wrack_tag_r <= '0;
      dq_vld_r <= 2'b00;
      dq_id_r <= '0;
    end else if (ce) begin
      rx_r <= rx_nxt;
      beat_r <= beat_nxt;
      last_r <= last_nxt;
      hdr_r <= hdr_nxt;
      kind_r <= kind_nxt;
      byp_r <= byp_nxt;
      pay_r <= pay_nxt;
      be_r <= be_nxt;
      ovf_r <= ovf_nxt;
      e_hdr_r <= e_hdr_nxt;
      e_pay_r <= e_pay_nxt;
      e_be_r <= e_be_nxt;
      e_kind_r <= e_kind_nxt;
      e_dep_r <= e_dep_nxt;
      e_hasdep_r <= e_hasdep_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      wrack_r <= wrack_nxt;
      wrack_tag_r <= wrack_tag_nxt;
      dq_vld_r <= dq_vld_nxt;
      dq_id_r <= dq_id_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from queue heads
  assign oq_vld = q_vld[IDQ_OQ];
  assign bq_vld = q_vld[IDQ_BQ];
  assign oq_kind = e_kind_r[IDQ_OQ][rp_r[IDQ_OQ][IDQ_TAG_W-1:0]];
  assign oq_hdr = e_hdr_r[IDQ_OQ][rp_r[IDQ_OQ][IDQ_TAG_W-1:0]];
  assign oq_pay = e_pay_r[IDQ_OQ][rp_r[IDQ_OQ][IDQ_TAG_W-1:0]];
  assign oq_be = e_be_r[IDQ_OQ][rp_r[IDQ_OQ][IDQ_TAG_W-1:0]];
  assign bq_kind = e_kind_r[IDQ_BQ][rp_r[IDQ_BQ][IDQ_TAG_W-1:0]];
  assign bq_hdr = e_hdr_r[IDQ_BQ][rp_r[IDQ_BQ][IDQ_TAG_W-1:0]];
  assign bq_pay = e_pay_r[IDQ_BQ][rp_r[IDQ_BQ][IDQ_TAG_W-1:0]];
  assign bq_be = e_be_r[IDQ_BQ][rp_r[IDQ_BQ][IDQ_TAG_W-1:0]];
  // DMA traffic is always marked non-allocating
  assign oq_no_alloc = 1'b1; // RQ22
  assign overflow = ovf_r;
  assign lnk.wrack_vld = wrack_r;
  assign lnk.wrack_tag = wrack_tag_r;
  assign lnk.dq_vld = dq_vld_r;
  assign lnk.dq_id = dq_id_r;
endmodule

//--- idq_pkg.sv
// Shared constants, types and helpers for the inbound DMA credit queue link
package idq_pkg;
  // ==========================================================
  // Sizes
  localparam int IDQ_DEPTH = 16;
  localparam int IDQ_PTR_W = 5;
  localparam int IDQ_DATA_W = 128;
  localparam int IDQ_BE_W = 16;
  localparam int IDQ_PAR_W = 4;
  localparam int IDQ_TAG_W = 4;
  localparam int IDQ_WR_BEATS = 4;
  localparam logic [2:0] IDQ_LAST_BEAT = 3'h3;
  localparam logic [4:0] IDQ_CREDITS = 5'h10;
  localparam logic [IDQ_PTR_W-1:0] IDQ_PEND_MAX = 5'h10;
  // ==========================================================
  // Header field layout
  localparam int IDQ_HDR_TAG_LSB = 0;
  localparam int IDQ_HDR_BMA_BIT = 8;
  localparam int IDQ_HDR_INT_BIT = 9;
  localparam int IDQ_HDR_ADDR_LSB = 64;
  localparam int IDQ_ADDR_LOW_W = 6;
  // Queue indices
  localparam int IDQ_OQ = 0;
  localparam int IDQ_BQ = 1;
  // ==========================================================
  // Packet kinds
  typedef enum logic [1:0] {
    IDQ_K_READ,
    IDQ_K_WRITE,
    IDQ_K_INT,
    IDQ_K_PIO
  } idq_kind_t;

  typedef logic [IDQ_WR_BEATS-1:0][IDQ_DATA_W-1:0] idq_pay_t;
  typedef logic [IDQ_WR_BEATS-1:0][IDQ_BE_W-1:0] idq_be_t;

  // Entries of the other queue still ahead of a recorded pointer
  function automatic logic idq_pending(input logic [IDQ_PTR_W-1:0] dep,
                                       input logic [IDQ_PTR_W-1:0] rptr);
    logic [IDQ_PTR_W-1:0] diff;
    diff = dep - rptr;
    return (diff != '0) && (diff <= IDQ_PEND_MAX);
  endfunction

  // Even parity per 32-bit lane
  function automatic logic [IDQ_PAR_W-1:0] idq_parity(input logic [IDQ_DATA_W-1:0] d);
    logic [IDQ_PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < IDQ_PAR_W; i++) begin
      p[i] = ^d[i*32 +: 32];
    end
    return p;
  endfunction
endpackage

//--- idq_link_if.sv
// Inbound link between the DMA sender and the inbound queue port
`timescale 1ns/10ps
interface idq_link_if;
  import idq_pkg::*;
  logic hdr_vld;
  logic [IDQ_DATA_W-1:0] data;
  logic datareq;
  logic single_beat_payload;
  logic reqbypass;
  logic [IDQ_PAR_W-1:0] parity;
  logic [IDQ_BE_W-1:0] byte_lane_enables;
  logic wrack_vld;
  logic [IDQ_TAG_W-1:0] wrack_tag;
  logic [1:0] dq_vld;
  logic [1:0][IDQ_TAG_W-1:0] dq_id;

  modport dev (
    input hdr_vld, data, datareq, single_beat_payload, reqbypass, parity,
    input byte_lane_enables,
    output wrack_vld, wrack_tag, dq_vld, dq_id
  );
  modport dma (
    output hdr_vld, data, datareq, single_beat_payload, reqbypass, parity,
    output byte_lane_enables,
    input wrack_vld, wrack_tag, dq_vld, dq_id
  );
endinterface

//--- idq_dma_sender.sv
// DMA sender end: credit pools, id allocation and packet framing
`timescale 1ns/10ps
module idq_dma_sender
  import idq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  idq_link_if.dma lnk,
  input wire logic req_vld,
  input wire idq_kind_t req_kind,
  input wire logic [IDQ_DATA_W-1:0] req_hdr,
  input wire idq_pay_t req_pay,
  input wire idq_be_t req_be,
  output logic req_ready,
  output logic [IDQ_TAG_W-1:0] req_tag,
  input wire logic rd_done,
  input wire logic [IDQ_TAG_W-1:0] rd_done_tag,
  input wire logic int_done,
  input wire logic [IDQ_TAG_W-1:0] int_done_tag,
  output logic [4:0] dma_credits,
  output logic [4:0] pio_credits
);
  typedef enum logic {IDQ_TX_IDLE, IDQ_TX_BEAT} idq_tx_t;

  // ==========================================================
  // State
  idq_tx_t st_r, st_nxt;
  logic [2:0] beat_r, beat_nxt, nbeats_r, nbeats_nxt;
  logic [IDQ_DEPTH-1:0] busy_r, busy_nxt;
  logic [4:0] pio_r, pio_nxt;
  idq_pay_t pay_r, pay_nxt;
  idq_be_t be_r, be_nxt;
  logic hv_r, hv_nxt, dr_r, dr_nxt, sb_r, sb_nxt, byp_r, byp_nxt;
  logic [IDQ_DATA_W-1:0] dat_r, dat_nxt;
  logic [IDQ_PAR_W-1:0] par_r, par_nxt;
  logic [IDQ_BE_W-1:0] ble_r, ble_nxt;
  logic [IDQ_TAG_W-1:0] free_id;
  logic free_any, is_pio, slot_free, credit_ok, accept;
  logic [IDQ_DATA_W-1:0] hdr_out;

  // Lowest free DMA/interrupt id
  always_comb begin
    free_id = '0;
    free_any = 1'b0;
    for (int i = IDQ_DEPTH - 1; i >= 0; i--) begin
      if (!busy_r[i]) begin
        free_id = IDQ_TAG_W'(i);
        free_any = 1'b1;
      end
    end
  end

  // Free once the last beat is on the wire; earlier would overwrite that beat
  assign slot_free = (st_r == IDQ_TX_IDLE);
  assign is_pio = (req_kind == IDQ_K_PIO);
  assign credit_ok = is_pio ? (pio_r != '0) : free_any; // RQ10 RQ13
  assign req_ready = ce && slot_free && credit_ok;
  assign accept = req_vld && req_ready;
  assign req_tag = is_pio ? req_hdr[IDQ_HDR_TAG_LSB +: IDQ_TAG_W] : free_id;
  assign dma_credits = IDQ_CREDITS - 5'($countones(busy_r));
  assign pio_credits = pio_r;

  // Header with assigned id; read and write addresses cacheline-aligned
  always_comb begin
    hdr_out = req_hdr;
    hdr_out[IDQ_HDR_TAG_LSB +: IDQ_TAG_W] = req_tag; // RQ4
    if (req_kind == IDQ_K_READ || req_kind == IDQ_K_WRITE) begin
      hdr_out[IDQ_HDR_ADDR_LSB +: IDQ_ADDR_LOW_W] = '0; // RQ15
    end
  end

  // ==========================================================
  // Next-state: credits, ids and framing
  always_comb begin
    st_nxt = st_r;
    beat_nxt = beat_r;
    nbeats_nxt = nbeats_r;
    busy_nxt = busy_r;
    pio_nxt = pio_r;
    pay_nxt = pay_r;
    be_nxt = be_r;
    hv_nxt = 1'b0;
    dr_nxt = 1'b0;
    sb_nxt = 1'b0;
    byp_nxt = 1'b0;
    dat_nxt = '0;
    par_nxt = '0;
    ble_nxt = '0;
    // Ids come back only once their own event is seen
    if (lnk.wrack_vld) busy_nxt[lnk.wrack_tag] = 1'b0; // RQ4
    if (rd_done) busy_nxt[rd_done_tag] = 1'b0; // RQ4
    if (int_done) busy_nxt[int_done_tag] = 1'b0; // RQ4
    if (lnk.dq_vld[IDQ_BQ]) pio_nxt = pio_nxt + 5'h1; // RQ3
    if (st_r == IDQ_TX_BEAT) begin
      // Payload beats: header valid low, parity driven
      hv_nxt = 1'b0;
      dat_nxt = pay_r[beat_r];
      par_nxt = idq_parity(pay_r[beat_r]); // RQ17
      ble_nxt = be_r[beat_r]; // RQ18
      beat_nxt = beat_r + 3'h1;
      if (beat_r == nbeats_r) st_nxt = IDQ_TX_IDLE;
    end
    if (accept) begin
      hv_nxt = 1'b1;
      dat_nxt = hdr_out;
      par_nxt = '0;
      ble_nxt = '0;
      byp_nxt = is_pio; // RQ9
      dr_nxt = (req_kind != IDQ_K_READ); // RQ14 RQ16
      sb_nxt = (req_kind == IDQ_K_INT) || is_pio;
      pay_nxt = req_pay;
      be_nxt = req_be;
      beat_nxt = '0;
      nbeats_nxt = (req_kind == IDQ_K_WRITE) ? IDQ_LAST_BEAT : 3'h0;
      st_nxt = (req_kind == IDQ_K_READ) ? IDQ_TX_IDLE : IDQ_TX_BEAT;
      if (is_pio) begin
        pio_nxt = pio_nxt - 5'h1; // RQ3
      end else begin
        busy_nxt[free_id] = 1'b1; // RQ19
      end
    end
  end

  // Registers; counters start full after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= IDQ_TX_IDLE;
      beat_r <= '0;
      nbeats_r <= '0;
      busy_r <= '0; // RQ23
      pio_r <= IDQ_CREDITS; // RQ23
      pay_r <= '0;
      be_r <= '0;
      hv_r <= 1'b0;
      dr_r <= 1'b0;
      sb_r <= 1'b0;
      byp_r <= 1'b0;
      dat_r <= '0;
      par_r <= '0;
      ble_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      beat_r <= beat_nxt;
      nbeats_r <= nbeats_nxt;
      busy_r <= busy_nxt;
      pio_r <= pio_nxt;
      pay_r <= pay_nxt;
      be_r <= be_nxt;
      hv_r <= hv_nxt;
      dr_r <= dr_nxt;
      sb_r <= sb_nxt;
      byp_r <= byp_nxt;
      dat_r <= dat_nxt;
      par_r <= par_nxt;
      ble_r <= ble_nxt;
    end
  end

  assign lnk.hdr_vld = hv_r;
  assign lnk.data = dat_r;
  assign lnk.datareq = dr_r;
  assign lnk.single_beat_payload = sb_r;
  assign lnk.reqbypass = byp_r;
  assign lnk.parity = par_r;
  assign lnk.byte_lane_enables = ble_r;
endmodule

//--- idq_link_asserts.sv
// Concurrent checks on the link between the DMA sender and the inbound port
`timescale 1ns/10ps
module idq_link_asserts
  import idq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hdr_vld,
  input wire logic [IDQ_DATA_W-1:0] data,
  input wire logic datareq,
  input wire logic single_beat_payload,
  input wire logic reqbypass,
  input wire logic [IDQ_PAR_W-1:0] parity,
  input wire logic [IDQ_BE_W-1:0] byte_lane_enables,
  input wire logic wrack_vld,
  input wire logic [IDQ_TAG_W-1:0] wrack_tag,
  input wire logic [1:0] dq_vld,
  input wire logic [1:0][IDQ_TAG_W-1:0] dq_id
);
  // ==========================================================
  // Helper logic
  logic par_ok;
  logic wr_hdr;
  logic [5:0] oq_occ_r, oq_occ_nxt, bq_occ_r, bq_occ_nxt;

  // Lane parity worked out here, apart from the sender's own function
  assign par_ok = (parity == {^data[127:96], ^data[95:64], ^data[63:32], ^data[31:0]});
  assign wr_hdr = hdr_vld && datareq && !single_beat_payload;

  // Occupancy counted from headers and credit returns, so it never falls below the real queue
  always_comb begin
    oq_occ_nxt = oq_occ_r + {5'h00, hdr_vld && !reqbypass} - {5'h00, dq_vld[0]};
    bq_occ_nxt = bq_occ_r + {5'h00, hdr_vld && reqbypass} - {5'h00, dq_vld[1]};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oq_occ_r <= 6'h00;
      bq_occ_r <= 6'h00;
    end else begin
      oq_occ_r <= oq_occ_nxt;
      bq_occ_r <= bq_occ_nxt;
    end
  end

  // ==========================================================
  // Assertions
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  reset_quiet_a: assert property (
    $rose(rst_n) |-> !hdr_vld && !wrack_vld && dq_vld == 2'h0)
    else $error("link busy right after reset");
  write_frame_a: assert property (
    wr_hdr |=> (!hdr_vld && par_ok) [*4])
    else $error("write beats malformed");
  hdr_lanes_a: assert property (
    hdr_vld |-> byte_lane_enables == '0 && parity == '0)
    else $error("header cycle drives lanes");
  write_queue_a: assert property (
    wr_hdr |-> !reqbypass)
    else $error("write not sent to ordered queue");
  beat_frame_a: assert property (
    hdr_vld && datareq && single_beat_payload |=> !hdr_vld && par_ok)
    else $error("single payload beat malformed");
  read_frame_a: assert property (
    hdr_vld && !datareq |-> !single_beat_payload && !reqbypass)
    else $error("read header malformed");
  addr_align_a: assert property (
    hdr_vld && !(datareq && single_beat_payload)
      |-> data[IDQ_HDR_ADDR_LSB +: IDQ_ADDR_LOW_W] == '0)
    else $error("DMA address not line aligned");
  ack_deq_a: assert property (
    wrack_vld |-> dq_vld[0] && (dq_id[0] == wrack_tag || dq_id[0] == '0))
    else $error("write ack without matching dequeue");
  oq_bound_a: assert property (oq_occ_r <= 6'h10)
    else $error("ordered queue over sixteen");
  bq_bound_a: assert property (bq_occ_r <= 6'h10)
    else $error("bypass queue over sixteen");

  // Main scenarios reached
  wr_seen_c: cover property (wr_hdr);
  ack_seen_c: cover property (wrack_vld);
  bq_seen_c: cover property (dq_vld[1]);
endmodule

//--- idq_inbound_tb_top.sv
// Testbench joining the DMA sender and the inbound port over the link
`timescale 1ns/10ps
module idq_inbound_tb_top
  import idq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic pcie_mode = 1'b1;
  logic l2_writes_idle = 1'b1;
  logic oq_ready = 1'b0;
  logic bq_ready = 1'b0;
  logic req_vld = 1'b0;
  idq_kind_t req_kind = IDQ_K_READ;
  logic [IDQ_DATA_W-1:0] req_hdr = '0;
  idq_pay_t req_pay = '0;
  idq_be_t req_be = '0;
  logic rd_done = 1'b0;
  logic int_done = 1'b0;
  logic [IDQ_TAG_W-1:0] rd_done_tag = '0;
  logic [IDQ_TAG_W-1:0] int_done_tag = '0;
  logic req_ready, oq_vld, oq_no_alloc, bq_vld, overflow;
  logic [IDQ_TAG_W-1:0] req_tag;
  logic [4:0] dma_credits, pio_credits;
  idq_kind_t oq_kind, bq_kind;
  logic [IDQ_DATA_W-1:0] oq_hdr, bq_hdr;
  idq_pay_t oq_pay, bq_pay;
  idq_be_t oq_be, bq_be;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [6:0] drain_q[$];
  logic [5:0] ack_q[$];

  idq_link_if lnk ();

  idq_dma_sender idq_dma_sender_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .lnk(lnk), .req_vld(req_vld), .req_kind(req_kind), .req_hdr(req_hdr),
    .req_pay(req_pay), .req_be(req_be), .req_ready(req_ready), .req_tag(req_tag),
    .rd_done(rd_done), .rd_done_tag(rd_done_tag), .int_done(int_done),
    .int_done_tag(int_done_tag), .dma_credits(dma_credits), .pio_credits(pio_credits));

  idq_inbound idq_inbound_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .pcie_mode(pcie_mode), .lnk(lnk), .l2_writes_idle(l2_writes_idle), .oq_vld(oq_vld),
    .oq_ready(oq_ready), .oq_kind(oq_kind), .oq_hdr(oq_hdr), .oq_pay(oq_pay),
    .oq_be(oq_be), .oq_no_alloc(oq_no_alloc), .bq_vld(bq_vld), .bq_ready(bq_ready),
    .bq_kind(bq_kind), .bq_hdr(bq_hdr), .bq_pay(bq_pay), .bq_be(bq_be),
    .overflow(overflow));

  idq_link_asserts idq_link_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .hdr_vld(lnk.hdr_vld), .data(lnk.data), .datareq(lnk.datareq),
    .single_beat_payload(lnk.single_beat_payload), .reqbypass(lnk.reqbypass),
    .parity(lnk.parity), .byte_lane_enables(lnk.byte_lane_enables),
    .wrack_vld(lnk.wrack_vld), .wrack_tag(lnk.wrack_tag), .dq_vld(lnk.dq_vld),
    .dq_id(lnk.dq_id));

  // ==========================================================
  // Clock, drain log and hang guard
  always #2 clk_sys = ~clk_sys;

  // Log every drain and credit return in the order it happens
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (oq_vld && oq_ready) drain_q.push_back({1'b0, oq_kind, oq_hdr[3:0]});
    if (bq_vld && bq_ready) drain_q.push_back({1'b1, bq_kind, bq_hdr[3:0]});
    if (lnk.wrack_vld) ack_q.push_back({2'h0, lnk.wrack_tag});
    if (lnk.dq_vld[0]) ack_q.push_back({2'h1, lnk.dq_id[0]});
    if (lnk.dq_vld[1]) ack_q.push_back({2'h2, lnk.dq_id[1]});
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [511:0] seen, input logic [511:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Holds the request until taken; caller lowers req_vld after the last one
  task automatic send(input idq_kind_t k, input logic [IDQ_DATA_W-1:0] h,
                      output logic [IDQ_TAG_W-1:0] t);
    int n;
    n = 0;
    req_vld <= 1'b1;
    req_kind <= k;
    req_hdr <= h;
    @(posedge clk_sys);
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100) fails++;
    t = req_tag;
  endtask

  // Idle cycle after each pulse so no signal is set twice in one step
  task automatic free_id(input logic is_int, input logic [IDQ_TAG_W-1:0] t);
    rd_done <= !is_int;
    int_done <= is_int;
    rd_done_tag <= t;
    int_done_tag <= t;
    @(posedge clk_sys);
    rd_done <= 1'b0;
    int_done <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_drain(input int n);
    int k;
    k = 0;
    while (drain_q.size() < n && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [IDQ_TAG_W-1:0] tg, t_rd, t_int;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("dma_credits", dma_credits, 16);
    chk("pio_credits", pio_credits, 16);
    chk("queues_idle", {oq_vld, bq_vld, overflow}, 0);
    // Write with mask off, held until earlier L2 writes have landed
    l2_writes_idle <= 1'b0;
    oq_ready <= 1'b1;
    req_pay <= {128'hA0, 128'hB1, 128'hC2, 128'hD3};
    req_be <= {4{16'h0F0F}};
    send(IDQ_K_WRITE, {58'h0, 6'h3F, 64'h5}, tg);
    req_vld <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("oq_kind", oq_kind, IDQ_K_WRITE);
    chk("oq_pay", oq_pay, req_pay);
    chk("oq_be", oq_be, {4{16'hFFFF}});
    chk("oq_no_alloc", oq_no_alloc, 1);
    chk("oq_addr_low", oq_hdr[69:64], 0);
    chk("write_held", drain_q.size(), 0);
    l2_writes_idle <= 1'b1;
    wait_drain(1);
    chk("wrack", ack_q[0], {2'h0, tg});
    chk("dq_id_oq", ack_q[1], {2'h1, tg});
    chk("dma_credits", dma_credits, 16);
    // Second write with the mask active keeps its lane enables
    oq_ready <= 1'b0;
    send(IDQ_K_WRITE, 128'h100, tg);
    req_vld <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("oq_be_mask", oq_be, req_be);
    oq_ready <= 1'b1;
    wait_drain(2);
    drain_q.delete();
    ack_q.delete();
    // Read, completion and interrupt back to back; drains keep queue order
    oq_ready <= 1'b0;
    send(IDQ_K_READ, 128'h0, t_rd);
    send(IDQ_K_PIO, 128'h9, tg);
    send(IDQ_K_INT, 128'h200, t_int);
    req_vld <= 1'b0;
    bq_ready <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("bq_waits", drain_q.size(), 0);
    chk("bq_kind", bq_kind, IDQ_K_PIO);
    chk("bq_pay", bq_pay[0], req_pay[0]);
    oq_ready <= 1'b1;
    wait_drain(3);
    chk("drain_0", drain_q[0], {1'b0, IDQ_K_READ, t_rd});
    chk("drain_1", drain_q[1], {1'b1, IDQ_K_PIO, 4'h9});
    chk("drain_2", drain_q[2], {1'b0, IDQ_K_INT, t_int});
    free_id(1'b0, t_rd);
    free_id(1'b1, t_int);
    chk("dma_credits", dma_credits, 16);
    chk("pio_credits", pio_credits, 16);
    drain_q.delete();
    // Fill both queues to sixteen; both credit counts end at zero with no overflow
    oq_ready <= 1'b0;
    bq_ready <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      send(IDQ_K_READ, 128'h0, tg);
    end
    for (int i = 0; i < 16; i++) begin
      send(IDQ_K_PIO, {124'h0, 4'(i)}, tg);
    end
    req_vld <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("dma_credits", dma_credits, 0);
    chk("pio_credits", pio_credits, 0);
    chk("overflow", overflow, 0);
    oq_ready <= 1'b1;
    bq_ready <= 1'b1;
    wait_drain(32);
    chk("drained", drain_q.size(), 32);
    for (int i = 0; i < 16; i++) begin
      free_id(1'b0, 4'(i));
    end
    chk("dma_credits", dma_credits, 16);
    chk("pio_credits", pio_credits, 16);
    drain_q.delete();
    ack_q.delete();
    // Network attachment: completions pass an older ordered entry
    pcie_mode <= 1'b0;
    oq_ready <= 1'b0;
    send(IDQ_K_READ, 128'h0, t_rd);
    send(IDQ_K_PIO, 128'h5, tg);
    req_vld <= 1'b0;
    wait_drain(1);
    chk("net_drain", drain_q[0], {1'b1, IDQ_K_PIO, 4'h5});
    chk("net_dq_id", ack_q[0], {2'h2, 4'h0});
    results();
  end
endmodule
